// *** src/qpcd_pkg.sv ***
// Constants and types for the quad potentiometer instruction decoder
package qpcd_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS       = 40;
  localparam int unsigned NV_WRITE_TIME_MS    = 10;
  localparam int unsigned NV_WRITE_CYCLES     =
    (NV_WRITE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WIPER_LOAD_DELAY_NS = 2000;
  localparam int unsigned WIPER_LOAD_CYC_INT  = WIPER_LOAD_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  WIPER_LOAD_CYCLES   = 6'(WIPER_LOAD_CYC_INT);
  localparam int unsigned BUSY_W              = 18;

  // Instruction opcodes
  localparam logic [3:0] OP_RD_WIPER          = 4'h9;
  localparam logic [3:0] OP_WR_WIPER          = 4'ha;
  localparam logic [3:0] OP_RD_SLOT           = 4'hb;
  localparam logic [3:0] OP_WR_SLOT           = 4'hc;
  localparam logic [3:0] OP_SLOT_TO_WIPER     = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_SLOT     = 4'he;
  localparam logic [3:0] OP_GLB_SLOT_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_GLB_WIPER_TO_SLOT = 4'h8;
  localparam logic [3:0] OP_STEP              = 4'h2;

  // Device type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEFAULT     = 4'ha;

  // Field values and bit counts
  localparam logic [1:0] ZERO_FIELD           = 2'h0;
  localparam logic [1:0] PRESET_SLOT          = 2'h0;
  localparam logic [5:0] WIPER_MAX            = 6'h3f;
  localparam logic [5:0] WIPER_MIN            = 6'h00;
  localparam logic [3:0] LAST_BIT             = 4'h7;
  localparam logic [3:0] BYTE_END             = 4'h8;

  typedef logic [5:0] qpcd_wiper_t;
  typedef qpcd_wiper_t [3:0] qpcd_taps_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] slot;
    logic [1:0] pot;
  } qpcd_instr_t;

  typedef struct packed {
    logic        valid;
    logic        global;
    logic [3:0]  idx;
    qpcd_wiper_t data;
    logic [1:0]  slot;
  } qpcd_nvwr_t;

  typedef enum logic [3:0] {
    ST_RECALL = 4'b0000,
    ST_IDLE   = 4'b0001,
    ST_ADDR   = 4'b0010,
    ST_INSTR  = 4'b0011,
    ST_WDATA  = 4'b0100,
    ST_RDATA  = 4'b0101,
    ST_STEP   = 4'b0110,
    ST_ACK    = 4'b0111,
    ST_IGNORE = 4'b1000
  } qpcd_state_t;

endpackage

// *** src/qpcd_core.sv ***
// Instruction decoder, wiper counters and stored slots of a quad digital potentiometer
`timescale 1ns/1ps

module qpcd_core
  import qpcd_pkg::*;
#(
  parameter int unsigned WR_CYCLES = NV_WRITE_CYCLES,
  parameter logic [3:0]  DEV_TYPE  = DEV_TYPE_DEFAULT
) (
  input  wire logic       i_mclk,        // System clock
  input  wire logic       i_reset,       // Power-up reset, synchronous, active high
  input  wire logic       i_scl,         // Serial bus clock
  input  wire logic       i_sda,         // Serial data pin level
  input  wire logic [3:0] i_addr_strap,  // Device address straps
  output logic            o_sda_o,       // Serial data drive value
  output logic            o_sda_oe,      // Serial data drive enable
  output qpcd_taps_t      o_taps,        // Tap selection of each pot
  output logic            o_busy,        // Nonvolatile write in progress
  output logic            o_step_active  // Step mode active
);

  function automatic logic [3:0] slot_idx(input logic [1:0] pot, input logic [1:0] slot);
    slot_idx = {pot, slot};
  endfunction

  function automatic qpcd_wiper_t step_wiper(input qpcd_wiper_t w, input logic up);
    if (up) begin
      step_wiper = (w == WIPER_MAX) ? w : w + 6'h01;
    end else begin
      step_wiper = (w == WIPER_MIN) ? w : w - 6'h01;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Link clock domain: capture each data bit on the serial clock rise

  logic scl_tgl_reg = 1'b0;
  logic scl_bit_reg = 1'b0;

  always_ff @(posedge i_scl) begin
    scl_tgl_reg <= ~scl_tgl_reg;
    scl_bit_reg <= i_sda;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system clock domain

  logic       tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic       bit_s1_reg, bit_s2_reg;
  logic       scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic       sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic [3:0] strap_s1_reg, strap_s2_reg;
  logic       bit_ev_reg;

  always_ff @(posedge i_mclk) begin
    tgl_s1_reg   <= scl_tgl_reg;
    tgl_s2_reg   <= tgl_s1_reg;
    tgl_s3_reg   <= tgl_s2_reg;
    bit_s1_reg   <= scl_bit_reg;
    bit_s2_reg   <= bit_s1_reg;
    scl_s1_reg   <= i_scl;
    scl_s2_reg   <= scl_s1_reg;
    scl_s3_reg   <= scl_s2_reg;
    sda_s1_reg   <= i_sda;
    sda_s2_reg   <= sda_s1_reg;
    sda_s3_reg   <= sda_s2_reg;
    strap_s1_reg <= i_addr_strap;
    strap_s2_reg <= strap_s1_reg;
    bit_ev_reg   <= i_reset ? 1'b0 : (tgl_s2_reg ^ tgl_s3_reg);
  end

  // Bit value is read one cycle after the toggle edge so it has settled
  wire bit_ev   = bit_ev_reg;
  wire bit_val  = bit_s2_reg;
  wire fall_ev  = scl_s3_reg & ~scl_s2_reg;
  wire scl_high = scl_s2_reg & scl_s3_reg;
  wire start_ev = scl_high & sda_s3_reg & ~sda_s2_reg;
  wire stop_ev  = scl_high & ~sda_s3_reg & sda_s2_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Registers and decoding

  qpcd_state_t          state_reg;
  qpcd_state_t          ack_next_reg;
  logic [3:0]           cnt_reg;
  logic [7:0]           shift_reg;
  logic [7:0]           rd_reg;
  qpcd_instr_t          instr_reg;
  qpcd_nvwr_t           nv_reg;
  qpcd_taps_t           wiper_reg;
  qpcd_taps_t           wiper_next;
  logic                 wiper_chg;
  qpcd_taps_t           taps_reg;
  logic [5:0]           load_cnt_reg;
  logic [BUSY_W-1:0]    busy_cnt_reg;
  logic                 busy_reg;
  logic                 sda_oe_reg;
  logic                 sda_o_reg;
  logic                 step_reg;
  qpcd_wiper_t          slot_mem [16] = '{default: 6'h00};

  wire [7:0]   byte_in   = {shift_reg[6:0], bit_val};
  qpcd_instr_t ins;
  assign ins = byte_in;

  wire byte_done  = bit_ev & (cnt_reg == LAST_BIT);
  wire addr_done  = byte_done & (state_reg == ST_ADDR);
  wire instr_done = byte_done & (state_reg == ST_INSTR);
  wire data_done  = byte_done & (state_reg == ST_WDATA);
  wire step_ev    = bit_ev & (state_reg == ST_STEP);
  wire addr_match = (byte_in == {DEV_TYPE, strap_s2_reg});

  // Instruction decode
  wire op_rdw  = (ins.opcode == OP_RD_WIPER) & (ins.slot == ZERO_FIELD);
  wire op_wrw  = (ins.opcode == OP_WR_WIPER) & (ins.slot == ZERO_FIELD);
  wire op_rds  = (ins.opcode == OP_RD_SLOT);
  wire op_wrs  = (ins.opcode == OP_WR_SLOT);
  wire op_s2w  = (ins.opcode == OP_SLOT_TO_WIPER);
  wire op_w2s  = (ins.opcode == OP_WIPER_TO_SLOT);
  wire op_gs2w = (ins.opcode == OP_GLB_SLOT_TO_WIPER) & (ins.pot == ZERO_FIELD);
  wire op_gw2s = (ins.opcode == OP_GLB_WIPER_TO_SLOT) & (ins.pot == ZERO_FIELD);
  wire op_step = (ins.opcode == OP_STEP) & (ins.slot == ZERO_FIELD);
  wire op_valid = op_rdw | op_wrw | op_rds | op_wrs | op_s2w | op_w2s |
                  op_gs2w | op_gw2s | op_step;

  // Three-byte instructions continue into a data byte
  wire qpcd_state_t instr_next = (op_rdw | op_rds) ? ST_RDATA :
                                 (op_wrw | op_wrs) ? ST_WDATA :
                                 op_step           ? ST_STEP  : ST_IGNORE;
  wire rx_accept = (state_reg == ST_ADDR)  ? (addr_match & ~busy_reg) :
                   (state_reg == ST_INSTR) ? op_valid : 1'b1;
  wire qpcd_state_t rx_next = (state_reg == ST_ADDR)  ? ST_INSTR :
                              (state_reg == ST_INSTR) ? instr_next : ST_IGNORE;

  wire qpcd_wiper_t rd_value = op_rdw ? wiper_reg[ins.pot]
                                      : slot_mem[slot_idx(ins.pot, ins.slot)];
  wire commit = stop_ev & nv_reg.valid & (state_reg != ST_RECALL);

  //////////////////////////////////////////////////////////////////////////////
  // Wiper counter next value

  always_comb begin
    wiper_next = wiper_reg;
    wiper_chg  = 1'b0;
    if (state_reg == ST_RECALL) begin
      for (int p = 0; p < 4; p++) begin
        wiper_next[p] = slot_mem[slot_idx(2'(p), PRESET_SLOT)];
      end
      wiper_chg = 1'b1;
    end else if (instr_done & op_s2w) begin
      wiper_next[ins.pot] = slot_mem[slot_idx(ins.pot, ins.slot)];
      wiper_chg = 1'b1;
    end else if (instr_done & op_gs2w) begin
      for (int p = 0; p < 4; p++) begin
        wiper_next[p] = slot_mem[slot_idx(2'(p), ins.slot)];
      end
      wiper_chg = 1'b1;
    end else if (data_done & (instr_reg.opcode == OP_WR_WIPER)) begin
      wiper_next[instr_reg.pot] = byte_in[5:0];
      wiper_chg = 1'b1;
    end else if (step_ev) begin
      wiper_next[instr_reg.pot] = step_wiper(wiper_reg[instr_reg.pot], bit_val);
      wiper_chg = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Protocol state machine

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg    <= ST_RECALL;
      ack_next_reg <= ST_IGNORE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      rd_reg       <= 8'h00;
      instr_reg    <= '0;
      nv_reg       <= '0;
      sda_oe_reg   <= 1'b0;
    end else if (state_reg == ST_RECALL) begin
      state_reg <= ST_IDLE;
    end else if (stop_ev) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      nv_reg     <= '0;
    end else if (start_ev) begin
      state_reg  <= ST_ADDR;
      cnt_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
      nv_reg     <= '0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_INSTR, ST_WDATA: begin
          if (bit_ev) begin
            shift_reg <= byte_in;
            cnt_reg   <= cnt_reg + 4'h1;
          end
          if (byte_done) begin
            cnt_reg      <= 4'h0;
            state_reg    <= rx_accept ? ST_ACK : ST_IGNORE;
            ack_next_reg <= rx_next;
          end
          if (instr_done) begin
            instr_reg <= ins;
            rd_reg    <= {ZERO_FIELD, rd_value};
          end
          if (instr_done & op_w2s) begin
            nv_reg <= '{1'b1, 1'b0, slot_idx(ins.pot, ins.slot),
                        wiper_reg[ins.pot], ins.slot};
          end
          if (instr_done & op_gw2s) begin
            nv_reg <= '{1'b1, 1'b1, 4'h0, 6'h00, ins.slot};
          end
          if (data_done & (instr_reg.opcode == OP_WR_SLOT)) begin
            nv_reg <= '{1'b1, 1'b0, slot_idx(instr_reg.pot, instr_reg.slot),
                        byte_in[5:0], instr_reg.slot};
          end
        end
        ST_ACK: begin
          if (fall_ev & ~sda_oe_reg) begin
            sda_oe_reg <= 1'b1;
          end else if (fall_ev) begin
            state_reg  <= ack_next_reg;
            cnt_reg    <= (ack_next_reg == ST_RDATA) ? 4'h1 : 4'h0;
            sda_oe_reg <= (ack_next_reg == ST_RDATA) & ~rd_reg[7];
            rd_reg     <= {rd_reg[6:0], 1'b0};
          end
        end
        ST_RDATA: begin
          if (fall_ev & (cnt_reg != BYTE_END)) begin
            sda_oe_reg <= ~rd_reg[7];
            rd_reg     <= {rd_reg[6:0], 1'b0};
            cnt_reg    <= cnt_reg + 4'h1;
          end else if (fall_ev) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= ST_IGNORE;
          end
        end
        ST_IDLE, ST_STEP, ST_IGNORE: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stored slots, write timer, wiper counters and tap outputs

  always_ff @(posedge i_mclk) begin
    if (commit & nv_reg.global) begin
      for (int p = 0; p < 4; p++) begin
        slot_mem[slot_idx(2'(p), nv_reg.slot)] <= wiper_reg[p];
      end
    end else if (commit) begin
      slot_mem[nv_reg.idx] <= nv_reg.data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      busy_cnt_reg  <= '0;
      busy_reg      <= 1'b0;
      wiper_reg     <= '0;
      taps_reg      <= '0;
      load_cnt_reg  <= 6'h00;
      sda_o_reg     <= 1'b0;
      step_reg      <= 1'b0;
    end else begin
      if (commit) begin
        busy_cnt_reg <= BUSY_W'(WR_CYCLES);
      end else if (busy_cnt_reg != '0) begin
        busy_cnt_reg <= busy_cnt_reg - BUSY_W'(1);
      end
      busy_reg  <= commit | (busy_cnt_reg > BUSY_W'(1));
      wiper_reg <= wiper_next;
      if (wiper_chg) begin
        load_cnt_reg <= WIPER_LOAD_CYCLES;
      end else if (load_cnt_reg != 6'h00) begin
        load_cnt_reg <= load_cnt_reg - 6'h01;
      end
      if (load_cnt_reg == 6'h01) begin
        taps_reg <= wiper_reg;
      end
      sda_o_reg <= 1'b0;
      step_reg  <= (state_reg == ST_STEP) & ~stop_ev & ~start_ev;
    end
  end

  assign o_sda_o       = sda_o_reg;
  assign o_sda_oe      = sda_oe_reg;
  assign o_taps        = taps_reg;
  assign o_busy        = busy_reg;
  assign o_step_active = step_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  wire qpcd_wiper_t sel_wiper = wiper_reg[instr_reg.pot];

  busy_no_ack_a: assert property (addr_done & busy_reg |=> state_reg == ST_IGNORE)
    else $error("address acknowledged during write cycle");
  addr_ack_a: assert property (addr_done & addr_match & ~busy_reg & ~stop_ev
    |=> state_reg == ST_ACK && ack_next_reg == ST_INSTR)
    else $error("matching address not acknowledged");
  write_start_a: assert property (commit |=> busy_reg && busy_cnt_reg == BUSY_W'(WR_CYCLES))
    else $error("write cycle not started at stop");
  write_len_a: assert property (busy_reg & ~commit
    |=> busy_cnt_reg == $past(busy_cnt_reg) - BUSY_W'(1))
    else $error("write timer not counting");
  bad_opcode_a: assert property (instr_done & ~op_valid & ~stop_ev & ~start_ev
    |=> state_reg == ST_IGNORE)
    else $error("undefined opcode accepted");
  step_up_a: assert property (step_ev & bit_val & (sel_wiper != WIPER_MAX)
    |=> sel_wiper == $past(sel_wiper) + 6'h01)
    else $error("step up did not increment");
  step_down_a: assert property (step_ev & ~bit_val & (sel_wiper != WIPER_MIN)
    |=> sel_wiper == $past(sel_wiper) - 6'h01)
    else $error("step down did not decrement");
  step_sat_a: assert property (step_ev & bit_val & (sel_wiper == WIPER_MAX)
    |=> sel_wiper == WIPER_MAX)
    else $error("step wrapped past top tap");
  stop_exit_a: assert property (stop_ev & (state_reg != ST_RECALL)
    |=> state_reg == ST_IDLE ##1 !step_reg)
    else $error("stop did not end the transaction");
  tap_follow_a: assert property (wiper_chg |=> (load_cnt_reg == WIPER_LOAD_CYCLES))
    else $error("wiper load delay not started");
  recall_a: assert property (state_reg == ST_RECALL
    |=> wiper_reg[0] == slot_mem[0] && wiper_reg[3] == slot_mem[12])
    else $error("power-up recall wrong");
  addr_reject_a: assert property (addr_done & ~addr_match & ~stop_ev
    |=> state_reg == ST_IGNORE)
    else $error("foreign address acknowledged");
  step_floor_a: assert property (step_ev & ~bit_val & (sel_wiper == WIPER_MIN)
    |=> sel_wiper == WIPER_MIN)
    else $error("step wrapped past bottom tap");
  step_on_a: assert property (state_reg == ST_STEP & ~stop_ev & ~start_ev
    |=> step_reg)
    else $error("step mode not flagged");
  tap_copy_a: assert property (load_cnt_reg == 6'h01 |=> taps_reg == $past(wiper_reg))
    else $error("taps did not take the wiper value");

  step_cov_c: cover property (step_ev ##1 step_ev);
  nvwrite_cov_c: cover property (commit ##1 busy_reg);
  read_cov_c: cover property (state_reg == ST_RDATA ##[1:400] state_reg == ST_IGNORE);
  floor_cov_c: cover property (step_ev & ~bit_val & (sel_wiper == WIPER_MIN));
  poll_cov_c: cover property (addr_done & busy_reg);

endmodule

// *** sim/qpcd_bus_master.sv ***
// Two-wire bus master model that frames and clocks instructions
`timescale 1ns/1ps

module qpcd_bus_master #(
  parameter int QTR = 640           // Quarter of one SCL bit period in ns
) (
  input  wire logic i_sda,          // Resolved data line
  output logic      o_scl,          // Serial clock, idle high
  output logic      o_sda_low       // High while pulling the data line low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Data changes only while SCL is low; SCL stands high between frames
  task automatic bit_out(input logic b);
    o_scl = 1'b0;
    #QTR o_sda_low = ~b;
    #QTR o_scl = 1'b1;
    #(2*QTR);
  endtask

  // Called from idle only, so SDA falls while SCL is high
  task automatic start();
    o_sda_low = 1'b1;
    #QTR;
  endtask

  task automatic stop();
    o_scl = 1'b0;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b0;
    #QTR;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    o_scl = 1'b0;
    #QTR o_sda_low = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR ack = ~i_sda;
    #QTR;
  endtask

  task automatic recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_scl = 1'b0;
      #QTR o_sda_low = 1'b0;
      #QTR o_scl = 1'b1;
      #QTR b[i] = i_sda;
      #QTR;
    end
    bit_out(1'b1);
  endtask
endmodule

// *** sim/quad_pot_command_decoder_tb_top.sv ***
// Self-checking bench for the quad potentiometer instruction decoder
`timescale 1ns/1ps

module quad_pot_command_decoder_tb_top;
  import qpcd_pkg::*;
  localparam int unsigned WRC   = 1000;
  localparam logic [3:0]  STRAP = 4'h5;
  localparam logic [7:0]  ADDR  = {DEV_TYPE_DEFAULT, STRAP};
  logic       i_mclk       = 1'b0;
  logic       i_reset      = 1'b1;
  logic [3:0] i_addr_strap = STRAP;
  logic       scl;
  logic       sda_low;
  logic       o_sda_o;
  logic       o_sda_oe;
  logic       o_busy;
  logic       o_step_active;
  qpcd_taps_t o_taps;
  wire logic  sda;
  logic       ack;
  logic [7:0] rd;
  int         fail_count = 0;
  int         num_checks = 0;

  // Open-drain line with pull-up
  assign sda = ~(sda_low | (o_sda_oe & ~o_sda_o));
  always #20 i_mclk = ~i_mclk;

  qpcd_bus_master u_master (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  qpcd_core #(.WR_CYCLES(WRC)) u_dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .i_addr_strap(i_addr_strap), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .o_taps(o_taps), .o_busy(o_busy), .o_step_active(o_step_active));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] ins, input logic exp_ack);
    u_master.start();
    u_master.send_byte(ADDR, ack);
    check(ack, 1, "address ack");
    u_master.send_byte(ins, ack);
    check(ack, exp_ack, "instruction ack");
  endtask

  task automatic wr(input logic [7:0] ins, input logic [7:0] d);
    cmd(ins, 1'b1);
    u_master.send_byte(d, ack);
    check(ack, 1, "data ack");
    u_master.stop();
  endtask

  task automatic rdv(input logic [7:0] ins, input logic [7:0] exp);
    cmd(ins, 1'b1);
    u_master.recv_byte(rd);
    check(rd, exp, "read data");
    u_master.stop();
  endtask

  task automatic poll(input logic exp);
    u_master.start();
    u_master.send_byte(ADDR, ack);
    check(ack, exp, "poll ack");
    u_master.stop();
  endtask

  task automatic wait_idle();
    cyc(4);
    check(o_busy, 1, "busy after stop");
    for (int i = 0; i < WRC + 50 && o_busy !== 1'b0; i++) cyc(1);
    check(o_busy, 0, "busy ends");
  endtask

  task automatic tap(input int p, input logic [5:0] exp);
    check({2'h0, o_taps[p]}, {2'h0, exp}, "tap");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2500000;
    fail_count++;
    conclude();
  end

  initial begin
    cyc(6);
    i_reset = 1'b0;
    cyc(60);
    for (int p = 0; p < 4; p++) tap(p, 6'h00);
    $display("test recall done");
    wr({OP_WR_WIPER, 2'h0, 2'h1}, 8'h2a);
    cyc(60);
    tap(1, 6'h2a);
    rdv({OP_RD_WIPER, 2'h0, 2'h1}, 8'h2a);
    u_master.start();
    u_master.send_byte({DEV_TYPE_DEFAULT, ~STRAP}, ack);
    check(ack, 0, "foreign address");
    u_master.stop();
    $display("test wiper access done");
    wr({OP_WR_SLOT, 2'h2, 2'h3}, 8'h15);
    cyc(4);
    poll(1'b0);
    wait_idle();
    poll(1'b1);
    rdv({OP_RD_SLOT, 2'h2, 2'h3}, 8'h15);
    $display("test slot write done");
    cmd({OP_GLB_SLOT_TO_WIPER, 2'h2, 2'h0}, 1'b1);
    u_master.stop();
    cyc(60);
    tap(3, 6'h15);
    tap(1, 6'h00);
    wr({OP_WR_WIPER, 2'h0, 2'h0}, 8'h3e);
    cmd({OP_WIPER_TO_SLOT, 2'h1, 2'h0}, 1'b1);
    u_master.stop();
    wait_idle();
    rdv({OP_RD_SLOT, 2'h1, 2'h0}, 8'h3e);
    wr({OP_WR_WIPER, 2'h0, 2'h3}, 8'h01);
    cmd({OP_SLOT_TO_WIPER, 2'h2, 2'h3}, 1'b1);
    u_master.stop();
    cyc(60);
    tap(3, 6'h15);
    cmd({OP_GLB_WIPER_TO_SLOT, 2'h3, 2'h0}, 1'b1);
    u_master.stop();
    wait_idle();
    rdv({OP_RD_SLOT, 2'h3, 2'h0}, 8'h3e);
    rdv({OP_RD_SLOT, 2'h3, 2'h3}, 8'h15);
    $display("test transfers done");
    cmd({OP_STEP, 2'h0, 2'h0}, 1'b1);
    repeat (3) u_master.bit_out(1'b1);
    check(o_step_active, 1, "step on");
    repeat (2) u_master.bit_out(1'b0);
    u_master.stop();
    cyc(60);
    check(o_step_active, 0, "step off");
    tap(0, 6'h3c);
    rdv({OP_RD_WIPER, 2'h0, 2'h0}, 8'h3c);
    $display("test step mode done");
    cmd({4'h3, 4'h0}, 1'b0);
    u_master.stop();
    cmd({OP_WR_WIPER, 2'h1, 2'h0}, 1'b0);
    u_master.stop();
    rdv({OP_RD_WIPER, 2'h0, 2'h0}, 8'h3c);
    $display("test refusals done");
    wr({OP_WR_SLOT, PRESET_SLOT, 2'h2}, 8'h2b);
    wait_idle();
    i_reset = 1'b1;
    cyc(6);
    i_reset = 1'b0;
    cyc(60);
    tap(2, 6'h2b);
    tap(0, 6'h00);
    cmd({OP_STEP, 2'h0, 2'h0}, 1'b1);
    repeat (2) u_master.bit_out(1'b0);
    u_master.stop();
    cyc(60);
    tap(0, 6'h00);
    rdv({OP_RD_WIPER, 2'h0, 2'h2}, 8'h2b);
    $display("test power-up recall done");
    conclude();
  end
endmodule
